// [fpw_flash_seq.sv]
/*
 Command sequencer of a serial NOR flash: burst-wrap setting, page program
 (single and quad lane, 3- or 4-byte address), 4 KB sector erase, with
 self-timed cycles, busy flag and write-enable latch. Assumes the array is
 written and erased outside through the memWr and eraseReq ports, that
 protLocked answers for protAddr within one clock, and that the read engine
 on the system clock steps readAddr through rdReq.
*/
// Operation
// - wrap command 77h: opcode, 24 or 32 dummy bits, one wrap byte
// - wrap byte bit 7 and bits 3..0 are ignored
// - wrap byte bit 4 low enables wrap, high gives linear reads
// - bits 6..5 pick wrap length 8, 16, 32 or 64 bytes
// - wrapped quad read returns to section start until chip select rises
// - stored wrap setting holds for all later quad reads until replaced
// - power-up and any reset set wrap disable, wrapping off
// - wrap setting also governs the 4-byte quad I/O read ECh
// - page program 02h: opcode, 24/32-bit address, one or more data bytes
// - page program refused unless write-enable latch set
// - program data past page end wraps to page start, overwriting
// - chip select must rise on a byte boundary or command is dropped; a wrap byte, once complete, is kept even if a cut byte follows
// - chip select rise starts self-timed program, busy high until done
// - finished page program clears write-enable latch
// - protected or locked pages are not programmed
// - opcode 12h always takes a 32-bit address
// - quad program 32h on four lanes needs quad enable and latch
// - opcode 34h is quad program with 32-bit address always
// - sector erase 20h sets addressed 4 KB sector to FFh, needs latch
// - erase keeps busy high, then clears it and latch; skips protected
// - in 4-byte address mode addressed commands take 32-bit address
`timescale 1ns/1ps
`include "fpw_defs.svh"

module fpw_flash_seq #(
   parameter int unsigned PAGE_BYTES = 256,
   parameter int unsigned PROG_CYCLES =
      `FPW_PROG_TIME_US * 1000 / `FPW_CLK_PERIOD_NS,
   parameter int unsigned ERASE_CYCLES =
      `FPW_ERASE_TIME_US * 1000 / `FPW_CLK_PERIOD_NS
) (
   // system clock and reset
   input wire logic clock,
   input wire logic rst,
   // serial link pins
   input wire logic spiClk,
   input wire logic spiCsN,
   input wire logic [3:0] spiIo,
   // configuration
   input wire logic quadEnable,
   input wire logic fourByteMode,
   input wire logic softReset,
   input wire logic protLocked,
   // read address stepping
   input wire fpw_pkg::fpw_rd_req_type rdReq,
   // status
   output logic busy,
   output logic writeLatchFlag,
   output logic [2:0] wrapSetting,
   output logic cmdDropped,
   output logic [31:0] readAddr,
   output logic [31:0] protAddr,
   // array access
   output fpw_pkg::fpw_mem_wr_type memWr,
   output fpw_pkg::fpw_erase_type eraseReq
);
   import fpw_pkg::*;

   localparam int IDX_W = $clog2(PAGE_BYTES);

   function automatic logic is_prog_op(input logic [7:0] op);
      return op == `FPW_OP_PP || op == `FPW_OP_PP4 ||
             op == `FPW_OP_QPP || op == `FPW_OP_QPP4;
   endfunction

   function automatic logic is_quad_op(input logic [7:0] op);
      return op == `FPW_OP_QPP || op == `FPW_OP_QPP4;
   endfunction

   // next read address: linear, or wrapped inside an aligned section
   function automatic logic [31:0] wrap_next(input logic [31:0] a,
                                             input logic [2:0] ws);
      logic [7:0] mask;
      logic [7:0] inc;
      mask = `FPW_WRAP_MASK_MAX >> (2'h3 - ws[`FPW_WRAP_LEN_MSB:
                                             `FPW_WRAP_LEN_LSB]);
      inc = a[7:0] + 8'h01;
      if (ws[`FPW_WRAP_DIS_POS])
         return a + 32'h1;
      return {a[31:8], (a[7:0] & ~mask) | (inc & mask)};
   endfunction

   // link domain
   fpw_byte_pair_type bytePair;
   logic linkToggle, linkPartial;

   fpw_spi_link u_link (
      .spiClk(spiClk),
      .rst(rst),
      .spiCsN(spiCsN),
      .spiIo(spiIo),
      .bytePair(bytePair),
      .byteToggle(linkToggle),
      .partialByte(linkPartial)
   );

   // crossings into the system clock
   logic csMeta_reg, csSync_reg, csPrev_reg;
   logic togMeta_reg, togSync_reg, togPrev_reg;
   logic partMeta_reg, partSync_reg;
   logic csRiseDly_reg;
   logic byteEvent, csRise, csFall;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         csMeta_reg <= 1'b1;
         csSync_reg <= 1'b1;
         csPrev_reg <= 1'b1;
         togMeta_reg <= 1'b0;
         togSync_reg <= 1'b0;
         togPrev_reg <= 1'b0;
         partMeta_reg <= 1'b0;
         partSync_reg <= 1'b0;
         csRiseDly_reg <= 1'b0;
      end else begin
         csMeta_reg <= spiCsN;
         csSync_reg <= csMeta_reg;
         csPrev_reg <= csSync_reg;
         togMeta_reg <= linkToggle;
         togSync_reg <= togMeta_reg;
         togPrev_reg <= togSync_reg;
         partMeta_reg <= linkPartial;
         partSync_reg <= partMeta_reg;
         csRiseDly_reg <= csRise;
      end
   end

   assign byteEvent = togSync_reg ^ togPrev_reg;
   assign csRise = csSync_reg & ~csPrev_reg;
   assign csFall = ~csSync_reg & csPrev_reg;

   // command decode state
   logic rdSel_reg;
   logic [3:0] byteCnt_reg;
   logic [7:0] opcode_reg;
   logic [31:0] cmdAddr_reg;
   logic [IDX_W-1:0] pageOff_reg;
   logic [7:0] pageBuf_reg [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pageValid_reg;
   logic [7:0] inByte;
   logic [3:0] addrBytes;
   logic aligned, progOk, eraseOk;

   always_comb begin
      inByte = rdSel_reg ? bytePair.odd : bytePair.even;
      if (opcode_reg == `FPW_OP_PP4 || opcode_reg == `FPW_OP_QPP4)
         addrBytes = `FPW_ADDR4_BYTES;
      else if (fourByteMode)
         addrBytes = `FPW_ADDR4_BYTES;
      else
         addrBytes = `FPW_ADDR3_BYTES;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdSel_reg <= 1'b0;
         byteCnt_reg <= 4'h0;
         opcode_reg <= 8'h00;
         cmdAddr_reg <= 32'h0;
      end else if (csFall) begin
         byteCnt_reg <= 4'h0;
         opcode_reg <= 8'h00;
         cmdAddr_reg <= 32'h0;
      end else if (byteEvent) begin
         rdSel_reg <= ~rdSel_reg;
         if (byteCnt_reg != `FPW_CNT_MAX)
            byteCnt_reg <= byteCnt_reg + 4'h1;
         if (byteCnt_reg == 4'h0)
            opcode_reg <= inByte;
         else if (byteCnt_reg <= addrBytes)
            cmdAddr_reg <= {cmdAddr_reg[23:0], inByte};
      end
   end

   // program data lands in the page buffer; offset wraps in the page
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pageOff_reg <= '0;
         pageValid_reg <= '0;
      end else if (csFall && !busy) begin
         pageValid_reg <= '0;
      end else if (byteEvent && !busy && is_prog_op(opcode_reg)) begin
         if (byteCnt_reg == addrBytes)
            pageOff_reg <= inByte[IDX_W-1:0];
         else if (byteCnt_reg > addrBytes) begin
            pageValid_reg[pageOff_reg] <= 1'b1;
            pageOff_reg <= pageOff_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (byteEvent && !busy && is_prog_op(opcode_reg) &&
          byteCnt_reg > addrBytes)
         pageBuf_reg[pageOff_reg] <= inByte;
   end

   // wrap setting: only bits 6..4 of the wrap byte are kept
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wrapSetting <= `FPW_WRAP_RESET;
      end else if (softReset) begin
         wrapSetting <= `FPW_WRAP_RESET;
      end else if (byteEvent && opcode_reg == `FPW_OP_WRAP &&
                   byteCnt_reg == addrBytes + 4'h1) begin
         wrapSetting <= inByte[`FPW_WRAP_SET_MSB:
                               `FPW_WRAP_SET_LSB];
      end
   end

   // read address generator for quad I/O reads (both EBh and ECh)
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readAddr <= 32'h0;
      end else if (rdReq.start) begin
         readAddr <= rdReq.addr;
      end else if (rdReq.step) begin
         if (rdReq.quad)
            readAddr <= wrap_next(readAddr, wrapSetting);
         else
            readAddr <= readAddr + 32'h1;
      end
   end

   // commit one cycle after the synchronized chip select rise is seen
   always_comb begin
      aligned = !partSync_reg;
      progOk = is_prog_op(opcode_reg) && byteCnt_reg > addrBytes + 4'h1 &&
               writeLatchFlag && !busy && !protLocked && aligned &&
               (!is_quad_op(opcode_reg) || quadEnable);
      eraseOk = opcode_reg == `FPW_OP_SE &&
                byteCnt_reg == addrBytes + 4'h1 && writeLatchFlag &&
                !busy && !protLocked && aligned;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         protAddr <= 32'h0;
      else
         protAddr <= cmdAddr_reg;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         cmdDropped <= 1'b0;
      else
         cmdDropped <= csRiseDly_reg && !progOk && !eraseOk &&
                       (is_prog_op(opcode_reg) ||
                        opcode_reg == `FPW_OP_SE);
   end

   // self-timed cycle sequencer
   fpw_state_type state_reg;
   logic isErase_reg;
   logic [IDX_W-1:0] walkIdx_reg;
   logic [31:0] timer_reg;
   logic [31:0] pageBase_reg;
   logic [31:0] cycleTarget;

   assign cycleTarget = isErase_reg ? ERASE_CYCLES - 1 : PROG_CYCLES - 1;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= FPW_IDLE;
         isErase_reg <= 1'b0;
         walkIdx_reg <= '0;
         timer_reg <= 32'h0;
         pageBase_reg <= 32'h0;
      end else begin
         unique case (state_reg)
            FPW_IDLE: begin
               timer_reg <= 32'h0;
               walkIdx_reg <= '0;
               if (csRiseDly_reg && (progOk || eraseOk)) begin
                  state_reg <= FPW_WRITE;
                  isErase_reg <= eraseOk;
                  pageBase_reg <= cmdAddr_reg;
               end
            end
            FPW_WRITE: begin
               timer_reg <= timer_reg + 32'h1;
               walkIdx_reg <= walkIdx_reg + 1'b1;
               if (isErase_reg || walkIdx_reg == IDX_W'(PAGE_BYTES - 1))
                  state_reg <= FPW_WAIT;
            end
            FPW_WAIT: begin
               timer_reg <= timer_reg + 32'h1;
               if (timer_reg >= cycleTarget)
                  state_reg <= FPW_DONE;
            end
            FPW_DONE: begin
               state_reg <= FPW_IDLE;
            end
         endcase
      end
   end

   // busy from the commit until the cycle ends
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         busy <= 1'b0;
      else if (state_reg == FPW_IDLE && csRiseDly_reg && (progOk || eraseOk))
         busy <= 1'b1;
      else if (state_reg == FPW_DONE)
         busy <= 1'b0;
   end

   // write-enable latch: set by write enable, cleared when a cycle ends
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         writeLatchFlag <= 1'b0;
      else if (state_reg == FPW_DONE)
         writeLatchFlag <= 1'b0;
      else if (csRiseDly_reg && opcode_reg == `FPW_OP_WREN &&
               byteCnt_reg == 4'h1 && aligned && !busy)
         writeLatchFlag <= 1'b1;
   end

   // array writes from the page buffer, one offset per clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         memWr <= '0;
      end else begin
         memWr.en <= state_reg == FPW_WRITE && !isErase_reg &&
                     pageValid_reg[walkIdx_reg];
         memWr.addr <= {pageBase_reg[31:IDX_W], walkIdx_reg};
         memWr.data <= pageBuf_reg[walkIdx_reg];
      end
   end

   // sector erase request with the 4 KB aligned base
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         eraseReq <= '0;
      end else begin
         eraseReq.start <= state_reg == FPW_WRITE && isErase_reg;
         eraseReq.addr <= {pageBase_reg[31:`FPW_SECTOR_LSB],
                           {`FPW_SECTOR_LSB{1'b0}}};
      end
   end

endmodule // fpw_flash_seq

// [fpw_defs.svh]
/*
 Constants of the flash program/erase/wrap sequencer: opcodes, wrap byte
 fields, reset values and timing figures. Assumes nothing of its users.
*/
`ifndef FPW_DEFS_SVH
`define FPW_DEFS_SVH

// command opcodes
`define FPW_OP_WRAP 8'h77
`define FPW_OP_PP 8'h02
`define FPW_OP_PP4 8'h12
`define FPW_OP_QPP 8'h32
`define FPW_OP_QPP4 8'h34
`define FPW_OP_SE 8'h20
`define FPW_OP_WREN 8'h06

// wrap byte fields and wrap setting layout {length[1:0], disable}
`define FPW_WRAP_SET_MSB 6
`define FPW_WRAP_SET_LSB 4
`define FPW_WRAP_DIS_POS 0
`define FPW_WRAP_LEN_MSB 2
`define FPW_WRAP_LEN_LSB 1
`define FPW_WRAP_RESET 3'h1
`define FPW_WRAP_MASK_MAX 8'h3f

// address phase lengths in bytes
`define FPW_ADDR3_BYTES 4'h3
`define FPW_ADDR4_BYTES 4'h4
`define FPW_CNT_MAX 4'hf

// erase geometry
`define FPW_SECTOR_LSB 12
`define FPW_ERASED_BYTE 8'hff

// timing
`define FPW_CLK_PERIOD_NS 10
`define FPW_PROG_TIME_US 400
`define FPW_ERASE_TIME_US 50000

`endif

// [fpw_pkg.sv]
/*
 Types of the flash program/erase/wrap sequencer.
 Assumes fpw_defs.svh holds the numeric constants.
*/
package fpw_pkg;

   typedef enum logic [1:0] {
      FPW_IDLE = 2'b00,
      FPW_WRITE = 2'b01,
      FPW_WAIT = 2'b11,
      FPW_DONE = 2'b10
   } fpw_state_type;

   typedef struct packed {
      logic en;
      logic [31:0] addr;
      logic [7:0] data;
   } fpw_mem_wr_type;

   typedef struct packed {
      logic start;
      logic [31:0] addr;
   } fpw_erase_type;

   typedef struct packed {
      logic start;
      logic step;
      logic quad;
      logic [31:0] addr;
   } fpw_rd_req_type;

   typedef struct packed {
      logic [7:0] even;
      logic [7:0] odd;
   } fpw_byte_pair_type;

endpackage

// [fpw_spi_link.sv]
/*
 Serial link front end on the flash clock: shifts command bytes in from one
 or four lanes and hands each byte to the core through a ping-pong pair and
 a toggle. Assumes the serial clock only runs while chip select is low.
*/
`timescale 1ns/1ps
`include "fpw_defs.svh"

module fpw_spi_link (
   // link pins
   input wire logic spiClk,
   input wire logic rst,
   input wire logic spiCsN,
   input wire logic [3:0] spiIo,
   // hand-off to core domain
   output fpw_pkg::fpw_byte_pair_type bytePair,
   output logic byteToggle,
   output logic partialByte
);
   import fpw_pkg::*;

   logic frameSeen_reg, quad_reg, opcodeDone_reg, sel_reg, toggle_reg;
   logic [2:0] phase_reg;
   logic [7:0] shift_reg;
   fpw_byte_pair_type pair_reg;
   logic [2:0] curPhase, phase_next;
   logic [7:0] shift_next;
   logic curQuad;

   always_comb begin
      curPhase = frameSeen_reg ? phase_reg : 3'h0;
      curQuad = frameSeen_reg & quad_reg;
      shift_next = curQuad ? {shift_reg[3:0], spiIo}
                           : {shift_reg[6:0], spiIo[0]};
      phase_next = curQuad ? curPhase + 3'h4 : curPhase + 3'h1;
   end

   // frame-local state, held clear while chip select is high
   always_ff @(posedge spiClk or posedge rst or posedge spiCsN) begin
      if (rst || spiCsN) begin
         frameSeen_reg <= 1'b0;
         opcodeDone_reg <= 1'b0;
         quad_reg <= 1'b0;
      end else begin
         frameSeen_reg <= 1'b1;
         if (phase_next == 3'h0 && !opcodeDone_reg) begin
            opcodeDone_reg <= 1'b1;
            quad_reg <= shift_next == `FPW_OP_QPP ||
                        shift_next == `FPW_OP_QPP4 ||
                        shift_next == `FPW_OP_WRAP;
         end
      end
   end

   // bit phase outlives the frame so the core can see a cut byte
   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         phase_reg <= 3'h0;
         shift_reg <= 8'h00;
         sel_reg <= 1'b0;
         toggle_reg <= 1'b0;
         pair_reg <= '0;
      end else begin
         phase_reg <= phase_next;
         shift_reg <= shift_next;
         if (phase_next == 3'h0) begin
            if (sel_reg)
               pair_reg.odd <= shift_next;
            else
               pair_reg.even <= shift_next;
            sel_reg <= ~sel_reg;
            toggle_reg <= ~toggle_reg;
         end
      end
   end

   assign bytePair = pair_reg;
   assign byteToggle = toggle_reg;
   assign partialByte = phase_reg != 3'h0;

endmodule // fpw_spi_link

// [fpw_flash_seq_asserts.sv]
/*
 Port assertions of fpw_flash_seq, bound after the module.
 Assumes fpw_pkg is compiled first.
*/
`timescale 1ns/1ps
module fpw_flash_seq_asserts (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // watched ports
   input wire logic softReset,
   input wire fpw_pkg::fpw_rd_req_type rdReq,
   input wire logic busy,
   input wire logic writeLatchFlag,
   input wire logic [2:0] wrapSetting,
   input wire logic [31:0] readAddr,
   input wire fpw_pkg::fpw_mem_wr_type memWr,
   input wire fpw_pkg::fpw_erase_type eraseReq
);
   import fpw_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // step inside an aligned section of 8 << l bytes
   function automatic logic [7:0] secNext(logic [7:0] a, logic [1:0] l);
      logic [7:0] m;
      m = (8'h08 << l) - 8'h01;
      return (a & ~m) | ((a + 8'h01) & m);
   endfunction
   property p_soft; softReset |=> wrapSetting == 3'h1; endproperty
   a_soft: assert property (p_soft)
      else $error("wrap default lost");
   property p_start; $rose(busy) |-> writeLatchFlag; endproperty
   a_start: assert property (p_start)
      else $error("cycle without latch");
   property p_end; $fell(busy) |-> !writeLatchFlag; endproperty
   a_end: assert property (p_end)
      else $error("latch kept after cycle");
   property p_wr; memWr.en |-> busy; endproperty
   a_wr: assert property (p_wr)
      else $error("write outside cycle");
   property p_erase;
      eraseReq.start |-> busy && eraseReq.addr[11:0] == 12'h000;
   endproperty
   a_erase: assert property (p_erase)
      else $error("bad erase request");
   property p_rd; rdReq.start |=> readAddr == $past(rdReq.addr); endproperty
   a_rd: assert property (p_rd)
      else $error("read start address");
   property p_lin;
      rdReq.step && !rdReq.start && (wrapSetting[0] || !rdReq.quad)
      |=> readAddr == $past(readAddr) + 32'h1;
   endproperty
   a_lin: assert property (p_lin)
      else $error("linear step");
   property p_wrap;
      rdReq.step && !rdReq.start && rdReq.quad && !wrapSetting[0] |=>
      readAddr == {$past(readAddr[31:8]),
      secNext($past(readAddr[7:0]), $past(wrapSetting[2:1]))};
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrapped step");
endmodule // fpw_flash_seq_asserts

bind fpw_flash_seq fpw_flash_seq_asserts u_asserts (.clock(clock),
   .rst(rst), .softReset(softReset), .rdReq(rdReq), .busy(busy),
   .writeLatchFlag(writeLatchFlag), .wrapSetting(wrapSetting),
   .readAddr(readAddr), .memWr(memWr), .eraseReq(eraseReq));

// [fpw_spi_host.sv]
/*
 Host end of the serial link: chip select, clock, four lanes.
 Assumes the bench fills txBytes and then calls runFrame.
*/
`timescale 1ns/1ps
module fpw_spi_host (
   // link pins
   output logic spiClk,
   output logic spiCsN,
   output logic [3:0] spiIo
);
   logic [7:0] txBytes[$];
   initial begin
      spiClk = 1'b0;
      spiCsN = 1'b1;
      spiIo = 4'h5;
   end
   task automatic putUnit(input logic [3:0] v);
      spiIo = v;
      #6 spiClk = 1'b1;
      #6 spiClk = 1'b0;
   endtask
   // bytes from quadFrom on go out on four lanes, high nibble first
   task automatic runFrame(input int quadFrom, input int extraBits);
      logic [7:0] b;
      #0.7 spiCsN = 1'b0;
      for (int i = 0; i < txBytes.size(); i++) begin
         b = txBytes[i];
         if (i >= quadFrom) begin
            putUnit(b[7:4]);
            putUnit(b[3:0]);
         end else
            for (int k = 7; k >= 0; k--)
               putUnit({{3{~b[k]}}, b[k]});
      end
      for (int k = 0; k < extraBits; k++)
         putUnit(4'h1);
      #6 spiCsN = 1'b1;
      spiIo = ~spiIo;
      txBytes.delete();
   endtask
endmodule // fpw_spi_host

// [fpw_flash_seq_bench.sv]
/*
 Self-checking bench of fpw_flash_seq driven through fpw_spi_host.
 Assumes short program and erase counts set below.
*/
`timescale 1ns/1ps
module fpw_flash_seq_bench;
   import fpw_pkg::*;
   logic clock, rst, quadEnable, fourByteMode, softReset, protLocked;
   logic spiClk, spiCsN, busy, writeLatchFlag, cmdDropped;
   logic [3:0] spiIo;
   logic [2:0] wrapSetting;
   logic [31:0] readAddr, lastWr, lastErase, protAddr;
   fpw_rd_req_type rdReq;
   fpw_mem_wr_type memWr;
   fpw_erase_type eraseReq;
   logic [7:0] img[256];
   logic [7:0] q[$];
   int mismatches, checks, wrCnt, drops, erases, cycles;

   fpw_flash_seq #(.PAGE_BYTES(256), .PROG_CYCLES(300), .ERASE_CYCLES(20))
   u_dut (.clock(clock), .rst(rst), .spiClk(spiClk), .spiCsN(spiCsN),
      .spiIo(spiIo), .quadEnable(quadEnable), .fourByteMode(fourByteMode),
      .softReset(softReset), .protLocked(protLocked), .rdReq(rdReq),
      .busy(busy), .writeLatchFlag(writeLatchFlag),
      .wrapSetting(wrapSetting), .cmdDropped(cmdDropped),
      .readAddr(readAddr), .protAddr(protAddr), .memWr(memWr),
      .eraseReq(eraseReq));
   fpw_spi_host u_host (.spiClk(spiClk), .spiCsN(spiCsN), .spiIo(spiIo));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (memWr.en === 1'b1) begin
         img[memWr.addr[7:0]] = memWr.data;
         lastWr = memWr.addr;
         wrCnt++;
      end
      if (cmdDropped === 1'b1) drops++;
      if (eraseReq.start === 1'b1) begin
         lastErase = eraseReq.addr;
         erases++;
      end
      if (cycles == 60000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic frame(input int quadFrom, input int extraBits);
      u_host.txBytes = q;
      u_host.runFrame(quadFrom, extraBits);
      tick(8);
   endtask
   task automatic wren();
      q = '{8'h06};
      frame(99, 0);
      chk(writeLatchFlag === 1'b1, "latch not set");
   endtask
   task automatic endCycle(input int limit);
      for (int n = 0; n < limit && busy === 1'b1; n++)
         tick(1);
      chk(busy === 1'b0, "cycle never ended");
      chk(writeLatchFlag === 1'b0, "latch left set");
   endtask
   task automatic readRun(input logic quad, input logic [31:0] a);
      tick(1);
      rdReq = '{1'b1, 1'b0, quad, a};
      tick(1);
      rdReq = '{1'b0, 1'b1, quad, a};
      tick(1);
      rdReq.step = 1'b0;
   endtask
   task automatic dropped(input int d, input string what);
      chk(drops == d + 1 && busy === 1'b0, what);
   endtask

   task automatic testWrap();
      logic [7:0] sec;
      for (int l = 0; l < 4; l++) begin
         fourByteMode = l[0];
         sec = 8'h08 << l;
         q = '{8'h77, 8'ha5, 8'ha5, 8'ha5};
         if (l[0]) q.push_back(8'ha5);
         q.push_back({1'b1, l[1:0], 5'h0f});
         frame(1, 0);
         chk(wrapSetting === {l[1:0], 1'b0}, "wrap byte");
         readRun(1'b1, 32'h0000_0340 + sec - 1);
         chk(readAddr === 32'h0000_0340, "section wrap");
      end
      readRun(1'b0, 32'h0000_037f);
      chk(readAddr === 32'h0000_0380, "plain read wrapped");
      softReset = 1'b1;
      tick(1);
      softReset = 1'b0;
      tick(1);
      chk(wrapSetting === 3'h1, "wrap default");
      readRun(1'b1, 32'h0000_037f);
      chk(readAddr === 32'h0000_0380, "wrap not off");
      fourByteMode = 1'b0;
      $display("test wrap done");
   endtask

   task automatic testProgram();
      int d;
      logic ok;
      d = drops;
      q = '{8'h02, 8'h00, 8'h10, 8'hfe, 8'h5a};
      frame(99, 0);
      dropped(d, "program without latch");
      wren();
      q = '{8'h02, 8'h00, 8'h10, 8'hfe};
      for (int i = 0; i < 258; i++)
         q.push_back(i < 256 ? i[7:0] : 8'hc0 + i[7:0]);
      wrCnt = 0;
      frame(999, 0);
      chk(busy === 1'b1, "no cycle");
      endCycle(400);
      ok = (wrCnt == 256) && (lastWr === 32'h0000_10ff);
      for (int i = 0; i < 256; i++)
         ok &= img[8'hfe + i[7:0]] === (i < 2 ? 8'hc0 + i[7:0] : i[7:0]);
      chk(ok, "page image");
      wren();
      for (int k = 0; k < 3; k++) begin
         d = drops;
         protLocked = (k != 0);
         if (k == 2)
            q = '{8'h20, 8'h00, 8'h20, 8'h00};
         else
            q = '{8'h02, 8'h00, 8'h20, 8'h00, 8'h11};
         frame(99, k == 0 ? 3 : 0);
         dropped(d, "bad frame taken");
         chk(protAddr === 32'h0000_2000, "lock address");
      end
      protLocked = 1'b0;
      fourByteMode = 1'b1;
      d = erases;
      q = '{8'h20, 8'h00, 8'h00, 8'h12, 8'h34};
      frame(99, 0);
      chk(erases == d + 1 && lastErase === 32'h0000_1000, "erase");
      endCycle(100);
      fourByteMode = 1'b0;
      $display("test program done");
   endtask

   task automatic testQuad();
      logic [7:0] op[3];
      int d;
      op = '{8'h12, 8'h32, 8'h34};
      wren();
      d = drops;
      q = '{8'h32, 8'h23, 8'h45, 8'h67, 8'h99};
      frame(1, 0);
      dropped(d, "quad without enable");
      quadEnable = 1'b1;
      for (int i = 0; i < 3; i++) begin
         if (i > 0) wren();
         q = '{op[i]};
         if (op[i] != 8'h32) q.push_back(8'h01);
         q = {q, 8'h23, 8'h45, 8'h67, 8'h99 + i[7:0]};
         frame(i == 0 ? 99 : 1, 0);
         endCycle(400);
         chk(lastWr === (i == 1 ? 32'h0023_4567 : 32'h0123_4567) &&
            img[8'h67] === 8'h99 + i[7:0], "quad address");
      end
      $display("test quad done");
   endtask

   initial begin
      rst = 1'b1;
      quadEnable = 1'b0;
      fourByteMode = 1'b0;
      softReset = 1'b0;
      protLocked = 1'b0;
      rdReq = '0;
      repeat (16) @(posedge clock);
      #1 rst = 1'b0;
      tick(4);
      chk(busy === 1'b0 && writeLatchFlag === 1'b0, "reset");
      chk(wrapSetting === 3'h1, "wrap reset");
      testWrap();
      testProgram();
      testQuad();
      stop_test();
   end
endmodule // fpw_flash_seq_bench
